// *** hw/gpp_consts.svh ***
// Register offsets, field positions and reset values for the port 5 / port 7 block
`ifndef GPP_CONSTS_SVH
`define GPP_CONSTS_SVH
`define GPP_OFS_P5_FUNC 4'h0
`define GPP_OFS_P5_DIR 4'h4
`define GPP_OFS_P5_DATA 4'h8
`define GPP_OFS_P5_PULL 4'hc
`define GPP_OFS_P7_DIR 4'h0
`define GPP_OFS_P7_DATA 4'h4
`define GPP_OFS_P7_TCTL 4'h8
`define GPP_PAGE_P5 1'b0
`define GPP_PAGE_P7 1'b1
`define GPP_RST_BYTE 8'h00
`define GPP_P5_PULL_MASK 8'h3f
`define GPP_P7_USED_MASK 8'h70
`define GPP_P7_RSVD_ONES 8'h8f
`define GPP_P7_TOP 6
`define GPP_P7_TCLK 5
`define GPP_P7_TRST 4
`define GPP_P5_OD7 7
`define GPP_P5_OD6 6
`define GPP_P5_TRIG 5
`define GPP_TCTL_OS_W 4
`endif

// *** hw/gpp_pkg.sv ***
// Types shared by the port 5 / port 7 block
package gpp_pkg;
  typedef logic [7:0] gpp_byte_t;
  typedef enum logic [1:0] {GPP_IDLE, GPP_ACK} gpp_bus_state_t;
endpackage : gpp_pkg

// *** hw/gpp_regfile.sv ***
// Byte register bank with registered read data
`timescale 1ns/10ps
`default_nettype none
module gpp_regfile #(
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_idx,
  output logic [7:0] rd_data,
  output logic [DEPTH*8-1:0] all_q
);
  logic [7:0] mem_r [DEPTH];
  logic [7:0] mem_nxt [DEPTH];
  logic [7:0] rd_nxt;

  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      mem_nxt[i] = mem_r[i];
    end
    if (wr_en)
    begin
      mem_nxt[wr_idx] = wr_data;
    end
    rd_nxt = mem_r[rd_idx];
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_r[i] <= 8'h00;
      end
      rd_data <= 8'h00;
    end
    else
    begin
      mem_r <= mem_nxt;
      rd_data <= rd_nxt;
    end
  end

  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      all_q[i*8 +: 8] = mem_r[i];
    end
  end
endmodule : gpp_regfile
`default_nettype wire

// *** hw/gpp_port57.sv ***
// Port 5 and port 7 general I/O with Wishbone register access
`timescale 1ns/10ps
`default_nettype none
`include "gpp_consts.svh"
module gpp_port57 (
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire gpp_pkg::gpp_byte_t port5_pin_in,
  output gpp_pkg::gpp_byte_t port5_pin_out,
  output gpp_pkg::gpp_byte_t port5_pin_oe,
  output gpp_pkg::gpp_byte_t port5_pullup_en,
  output logic [5:0] wake_input,
  output logic conversion_trigger_in,
  input wire logic [2:0] port7_pin_in,
  output logic [2:0] port7_pin_out,
  output logic [2:0] port7_pin_oe,
  input wire logic timer_compare_output,
  output logic timer_clock_input,
  output logic timer_reset_input
);
  import gpp_pkg::*;

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  gpp_bus_state_t st_r, st_nxt;
  logic req;
  logic wr_hit;
  logic [2:0] idx;
  logic [7:0] rd_raw;
  logic [7:0] rd_fix;
  logic [31:0] dat_nxt;
  logic [63:0] regs;
  logic mapped;
  logic ack_r, ack_nxt;

  // Register index: page bit, then word offset
  assign idx = {wb_adr_i[4], wb_adr_i[3:2]};
  assign req = wb_cyc_i && wb_stb_i;
  // Unmapped offset on port 7 page: writes dropped, reads zero
  assign mapped = (wb_adr_i[4] == `GPP_PAGE_P5) || (wb_adr_i[3:2] != 2'b11);
  // Request still stands while ack is out: never take it twice
  assign wr_hit = req && !ack_r && wb_we_i && wb_sel_i[0] && mapped && (st_r == GPP_IDLE);

  gpp_regfile #(
    .DEPTH(8)
  ) u_regs (
    .clk(clk),
    .reset(reset),
    .wr_en(wr_hit),
    .wr_idx(idx),
    .wr_data(wb_dat_i[7:0]),
    .rd_idx(idx),
    .rd_data(rd_raw),
    .all_q(regs)
  );

  // ----------------------------------------
  // Register fields
  // ----------------------------------------
  gpp_byte_t p5_func, port5_direction_bits, port5_data_latch, p5_pull_raw;
  gpp_byte_t port7_direction_control, port7_data_latch, timer_ctrl_status;
  assign p5_func = regs[0 +: 8];
  assign port5_direction_bits = regs[8 +: 8];
  assign port5_data_latch = regs[16 +: 8];
  assign p5_pull_raw = regs[24 +: 8];
  assign port7_direction_control = regs[32 +: 8] & `GPP_P7_USED_MASK;
  assign port7_data_latch = regs[40 +: 8] & `GPP_P7_USED_MASK;
  assign timer_ctrl_status = regs[48 +: 8];

  function automatic gpp_byte_t mix_read(gpp_byte_t dir, gpp_byte_t latch, gpp_byte_t pins);
    mix_read = (dir & latch) | (~dir & pins);
  endfunction : mix_read

  // ----------------------------------------
  // Port 5 pin logic
  // ----------------------------------------
  gpp_byte_t p5_gp_out;
  // Wake select forces input whatever the direction bit
  assign p5_gp_out = port5_direction_bits & ~{2'b00, p5_func[5:0]};

  always_comb
  begin
    port5_pin_out = port5_data_latch;
    port5_pin_oe = p5_gp_out;
    // Open drain: drive only the low level
    if (p5_func[`GPP_P5_OD7])
    begin
      port5_pin_out[7] = 1'b0;
      port5_pin_oe[7] = p5_gp_out[7] && !port5_data_latch[7];
    end
    if (p5_func[`GPP_P5_OD6])
    begin
      port5_pin_out[6] = 1'b0;
      port5_pin_oe[6] = p5_gp_out[6] && !port5_data_latch[6];
    end
  end

  // Pull-up off for any output pin
  assign port5_pullup_en = p5_pull_raw & `GPP_P5_PULL_MASK & ~port5_direction_bits;
  // Wake lines idle high when not selected
  assign wake_input = port5_pin_in[5:0] | ~p5_func[5:0];
  assign conversion_trigger_in = port5_pin_in[`GPP_P5_TRIG] | ~p5_func[`GPP_P5_TRIG];

  // ----------------------------------------
  // Port 7 pin logic
  // ----------------------------------------
  logic timer_owns_top;
  gpp_byte_t p7_pins;
  assign timer_owns_top = |timer_ctrl_status[`GPP_TCTL_OS_W-1:0];
  assign p7_pins = {1'b0, port7_pin_in, 4'h0};

  always_comb
  begin
    port7_pin_out = port7_data_latch[6:4];
    port7_pin_oe = port7_direction_control[6:4];
    if (timer_owns_top)
    begin
      port7_pin_out[2] = timer_compare_output;
      port7_pin_oe[2] = 1'b1;
    end
  end

  assign timer_clock_input = port7_pin_in[1];
  assign timer_reset_input = port7_pin_in[0];

  // ----------------------------------------
  // Read data shaping
  // ----------------------------------------
  // Live reads are combined after the bank so pin levels are current
  always_comb
  begin
    rd_fix = 8'h00;
    unique case ({wb_adr_i[4], wb_adr_i[3:2]})
      3'b000: rd_fix = rd_raw;
      3'b001: rd_fix = 8'h00;
      3'b010: rd_fix = mix_read(port5_direction_bits, rd_raw, port5_pin_in);
      3'b011: rd_fix = rd_raw & `GPP_P5_PULL_MASK;
      3'b100: rd_fix = 8'h00;
      3'b101: rd_fix = mix_read(port7_direction_control, rd_raw & `GPP_P7_USED_MASK,
                                p7_pins) | `GPP_P7_RSVD_ONES;
      3'b110: rd_fix = rd_raw;
      3'b111: rd_fix = 8'h00;
    endcase
  end

  always_comb
  begin
    st_nxt = st_r;
    dat_nxt = wb_dat_o;
    unique case (st_r)
      GPP_IDLE:
      begin
        if (req && !ack_r)
        begin
          st_nxt = GPP_ACK;
        end
      end
      GPP_ACK:
      begin
        st_nxt = GPP_IDLE;
        dat_nxt = {24'h000000, rd_fix};
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st_r <= GPP_IDLE;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      st_r <= st_nxt;
      wb_dat_o <= dat_nxt;
    end
  end

  // Two wait states, then ack; data registered with it
  assign ack_nxt = (st_r == GPP_ACK) && req;
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ack_r <= 1'b0;
    end
    else
    begin
      ack_r <= ack_nxt;
    end
  end
  assign wb_ack_o = ack_r;
endmodule : gpp_port57
`default_nettype wire

// *** sim/gpp_pins_model.sv ***
// Board-side pin model for ports 5 and 7
`timescale 1ns/10ps
`default_nettype none
module gpp_pins_model (
  input wire gpp_pkg::gpp_byte_t p5_out,
  input wire gpp_pkg::gpp_byte_t p5_oe,
  input wire gpp_pkg::gpp_byte_t p5_pu,
  input wire gpp_pkg::gpp_byte_t ext5,
  output gpp_pkg::gpp_byte_t p5_in,
  input wire logic [2:0] p7_out,
  input wire logic [2:0] p7_oe,
  input wire logic [2:0] ext7,
  output logic [2:0] p7_in
);
  import gpp_pkg::*;
  // Undriven pins show the board level, pulled high where enabled
  assign p5_in = (p5_oe & p5_out) | (~p5_oe & (p5_pu | ext5));
  assign p7_in = (p7_oe & p7_out) | (~p7_oe & ext7);
endmodule : gpp_pins_model
`default_nettype wire

// *** sim/gpp_port57_asserts.sv ***
// Port assertions for the port 5 / port 7 block
`timescale 1ns/10ps
`default_nettype none
module gpp_port57_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire gpp_pkg::gpp_byte_t port5_pin_oe,
  input wire gpp_pkg::gpp_byte_t port5_pullup_en,
  input wire logic [2:0] port7_pin_in,
  input wire logic [2:0] port7_pin_oe,
  input wire logic timer_clock_input,
  input wire logic timer_reset_input
);
  import gpp_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  property p_ack_soon; $rose(wb_stb_i) |-> ##[1:2] wb_ack_o; endproperty
  a_ack_soon: assert property (p_ack_soon) else $error("ack late");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  property p_ack_cause; wb_ack_o |-> $past(wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
  property p_pull_out; (port5_pullup_en & port5_pin_oe) == 8'h00; endproperty
  a_pull_out: assert property (p_pull_out) else $error("pull on output");
  property p_pull_rsvd; port5_pullup_en[7:6] == 2'h0; endproperty
  a_pull_rsvd: assert property (p_pull_rsvd) else $error("pull 7:6 on");
  property p_tclk; timer_clock_input == port7_pin_in[1]; endproperty
  a_tclk: assert property (p_tclk) else $error("timer clock");
  property p_trst; timer_reset_input == port7_pin_in[0]; endproperty
  a_trst: assert property (p_trst) else $error("timer reset");
  property p_rst_oe; $fell(reset) |-> port5_pin_oe == 8'h00 && port7_pin_oe == 3'h0; endproperty
  a_rst_oe: assert property (p_rst_oe) else $error("oe after reset");
endmodule : gpp_port57_asserts
bind gpp_port57 gpp_port57_asserts gpp_port57_asserts_inst (.clk, .reset, .wb_stb_i,
  .wb_ack_o, .port5_pin_oe, .port5_pullup_en, .port7_pin_in, .port7_pin_oe,
  .timer_clock_input, .timer_reset_input);
`default_nettype wire

// *** sim/gpp_port57_tb.sv ***
// Self-checking bench for the port 5 / port 7 block
`timescale 1ns/10ps
`default_nettype none
module gpp_port57_tb;
  import gpp_pkg::*;
  logic clk, reset, cyc, stb, we, tco, trg, tcl, trs, ack;
  logic [4:0] adr;
  logic [31:0] wd, rdo;
  gpp_byte_t p5i, p5o, p5e, p5u, x5, q;
  logic [5:0] wk;
  logic [2:0] p7i, p7o, p7e, x7;
  logic [3:0] sel;
  logic [20:0] rows [6];
  int n_fail, checks_done;
  gpp_port57 gpp_port57_inst (.clk, .reset, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdo), .wb_ack_o(ack),
    .port5_pin_in(p5i), .port5_pin_out(p5o), .port5_pin_oe(p5e), .port5_pullup_en(p5u),
    .wake_input(wk), .conversion_trigger_in(trg), .port7_pin_in(p7i), .port7_pin_out(p7o),
    .port7_pin_oe(p7e), .timer_compare_output(tco), .timer_clock_input(tcl),
    .timer_reset_input(trs));
  gpp_pins_model gpp_pins_model_inst (.p5_out(p5o), .p5_oe(p5e), .p5_pu(p5u), .ext5(x5),
    .p5_in(p5i), .p7_out(p7o), .p7_oe(p7e), .ext7(x7), .p7_in(p7i));
  task chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Holds the request until ack is sampled; no latency assumed
  task wb(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [7:0] r);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wd <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    r = rdo[7:0];
    cyc <= 0;
    stb <= 0;
    @(posedge clk);
  endtask : wb
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  // Whole run is about a hundred cycles; this limit is far beyond it
  initial
  begin
    #200000;
    n_fail++;
    tally_and_finish;
  end
  initial
  begin
    n_fail = 0;
    checks_done = 0;
    reset = 1;
    cyc = 0;
    stb = 0;
    we = 0;
    sel = 4'h1;
    adr = 5'h00;
    wd = 32'h0;
    tco = 1;
    x5 = 8'h1c;
    x7 = 3'h0;
    rows = '{{5'h04, 8'hf0, 8'h00}, {5'h08, 8'ha5, 8'hac}, {5'h0c, 8'hff, 8'h3f},
      {5'h10, 8'h50, 8'h00}, {5'h14, 8'hff, 8'hdf}, {5'h1c, 8'hff, 8'h00}};
    repeat (10) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    wb(0, 5'h14, 8'h00, q);
    chk(q, 8'h8f);
    wb(0, 5'h0c, 8'h00, q);
    chk(q, 8'h00);
    foreach (rows[i])
    begin
      wb(1, rows[i][20:16], rows[i][15:8], q);
      wb(0, rows[i][20:16], 8'h00, q);
      chk(q, rows[i][7:0]);
    end
    chk(p5e, 8'hf0);
    chk(p5o & p5e, 8'ha0);
    chk(p5u, 8'h0f);
    chk({5'h0, p7o & p7e}, 8'h05);
    // Byte lane off: the write must be dropped
    sel <= 4'h0;
    wb(1, 5'h04, 8'h0f, q);
    sel <= 4'h1;
    chk(p5e, 8'hf0);
    wb(1, 5'h0c, 8'h00, q);
    chk(p5u, 8'h00);
    wb(1, 5'h00, 8'ha0, q);
    chk(p5e, 8'h50);
    chk({7'h0, p5o[7]}, 8'h00);
    chk({1'b0, trg, wk}, 8'h1f);
    // Open-drain pin with latch low pulls the line
    wb(1, 5'h08, 8'h25, q);
    chk(p5e, 8'hd0);
    x7 <= 3'h3;
    tco <= 0;
    wb(1, 5'h10, 8'h10, q);
    wb(1, 5'h18, 8'h01, q);
    chk({4'h0, p7e[2], p7o[2], tcl, trs}, 8'h0b);
    reset <= 1;
    @(posedge clk);
    reset <= 0;
    @(posedge clk);
    chk(p5e | p5u, 8'h00);
    tally_and_finish;
  end
endmodule : gpp_port57_tb
`default_nettype wire
